// ===== rtl/sptp_params.svh
/*
 * Constants of the supply pulse trim programmer: timing, field positions,
 * register offsets and reset values.
 * Assumes inclusion by bare name and a 10 MHz system clock.
 */
`ifndef SPTP_PARAMS_SVH
`define SPTP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SPTP_CLK_MHZ       10
`define SPTP_T_MIN_US      20
`define SPTP_T_LONG_US     60
`define SPTP_MIN_CYC       (`SPTP_T_MIN_US * `SPTP_CLK_MHZ)
`define SPTP_LONG_CYC      (`SPTP_T_LONG_US * `SPTP_CLK_MHZ)

// ----------------------------------------------------------------------------
// Protocol figures
// ----------------------------------------------------------------------------
`define SPTP_KEY_MIN       7
`define SPTP_LOCK_ADDR     65
`define SPTP_NBITS         6
`define SPTP_TRIAL_MAX     63

// ----------------------------------------------------------------------------
// Register map (byte offsets) and fields
// ----------------------------------------------------------------------------
`define SPTP_OFS_CTRL      4'h0
`define SPTP_OFS_STATUS    4'h4
`define SPTP_OFS_CALIB     4'h8
`define SPTP_CTRL_EN       0
`define SPTP_CTRL_CLR      1
`define SPTP_CTRL_RST      1'h1
`define SPTP_ST_ARMED      0
`define SPTP_ST_LOCK       1
`define SPTP_ST_BLOW       2
`define SPTP_ST_VLOCK      3
`define SPTP_ST_CNT_LSB    8
`define SPTP_CAL_FUSE_LSB  8
`define SPTP_CAL_VOL_LSB   16

`endif

// ===== rtl/sptp_pkg.sv
/*
 * Types of the supply pulse trim programmer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sptp_pkg;

	// Supply level classes, delivered by the analog comparators
	typedef enum logic [1:0] {
		SPTP_LVL_ZERO   = 2'h0,
		SPTP_LVL_HOLD   = 2'h1,
		SPTP_LVL_COUNT  = 2'h2,
		SPTP_LVL_STROBE = 2'h3
	} sptp_lvl_t;

	// Decoder states, one-hot
	typedef enum logic [2:0] {
		SPTP_ST_IDLE = 3'h1,
		SPTP_ST_KEY  = 3'h2,
		SPTP_ST_ADDR = 3'h4
	} sptp_state_t;

	typedef logic [9:0] sptp_wid_t;
	typedef logic [6:0] sptp_addr_t;
	typedef logic [5:0] sptp_bits_t;

endpackage

// ===== rtl/sptp_top.sv
/*
 * Supply pulse trim programmer: decodes classified supply pulses into a
 * 6-bit switchpoint calibration value with per-bit fuses and a lock fuse,
 * plus a classic Wishbone slave for observation and control.
 * Assumes the supply level arrives already classified, asynchronously,
 * and that the fuse array latches a bit when its blow strobe is high.
 */
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`include "sptp_params.svh"

module sptp_top (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Classified supply level, asynchronous
	input  wire logic [1:0]        supply_class,
	// Wishbone slave
	input  wire logic              wb_cyc,
	input  wire logic              wb_stb,
	input  wire logic              wb_we,
	input  wire logic [3:0]        wb_adr,
	input  wire logic [3:0]        wb_sel,
	input  wire logic [31:0]       wb_dat_w,
	output logic      [31:0]       wb_dat_r,
	output logic                   wb_ack,
	// Trim and fuse outputs
	output logic      [5:0]        operate_switchpoint,
	output logic                   lock_fuse,
	output logic                   fuse_blow,
	output logic      [6:0]        fuse_addr
);

	// ------------------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------------------
	localparam sptp_pkg::sptp_wid_t  MIN_CYC  = sptp_pkg::sptp_wid_t'(`SPTP_MIN_CYC);
	localparam sptp_pkg::sptp_wid_t  LONG_CYC = sptp_pkg::sptp_wid_t'(`SPTP_LONG_CYC);
	localparam sptp_pkg::sptp_addr_t KEY_MIN  = sptp_pkg::sptp_addr_t'(`SPTP_KEY_MIN);
	localparam sptp_pkg::sptp_addr_t LOCK_A   = sptp_pkg::sptp_addr_t'(`SPTP_LOCK_ADDR);
	localparam sptp_pkg::sptp_addr_t NBITS_A  = sptp_pkg::sptp_addr_t'(`SPTP_NBITS);
	localparam sptp_pkg::sptp_addr_t TRIAL_A  = sptp_pkg::sptp_addr_t'(`SPTP_TRIAL_MAX);

	// Weight mask of a permanent address 1..6, else zero
	function automatic sptp_pkg::sptp_bits_t sptp_weight(input sptp_pkg::sptp_addr_t a);
		sptp_pkg::sptp_bits_t m;
		m = '0;
		if (a != '0 && a <= NBITS_A) begin
			m = sptp_pkg::sptp_bits_t'(1) << (a - 7'h01);
		end
		return m;
	endfunction

	// Decimal trial value of an address 1..63, else zero
	function automatic sptp_pkg::sptp_bits_t sptp_trial(input sptp_pkg::sptp_addr_t a);
		sptp_pkg::sptp_bits_t m;
		m = '0;
		if (a <= TRIAL_A) begin
			m = a[5:0];
		end
		return m;
	endfunction

	// ------------------------------------------------------------------------
	// Level synchroniser and filter
	// ------------------------------------------------------------------------
	logic [1:0]             lvl_s1_q;
	logic [1:0]             lvl_s2_q;
	logic [1:0]             lvl_s3_q;
	sptp_pkg::sptp_lvl_t    lvl_q;
	sptp_pkg::sptp_lvl_t    lvl_last_q;
	sptp_pkg::sptp_wid_t    wid_q;

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lvl_s1_q <= 2'h0;
			lvl_s2_q <= 2'h0;
			lvl_s3_q <= 2'h0;
		end else begin
			lvl_s1_q <= supply_class;
			lvl_s2_q <= lvl_s1_q;
			lvl_s3_q <= lvl_s2_q;
		end
	end

	// Filtered level and its previous value
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lvl_q      <= sptp_pkg::SPTP_LVL_ZERO;
			lvl_last_q <= sptp_pkg::SPTP_LVL_ZERO;
		end else begin
			if (lvl_s2_q == lvl_s3_q) begin
				lvl_q <= sptp_pkg::sptp_lvl_t'(lvl_s3_q);
			end
			lvl_last_q <= lvl_q;
		end
	end

	logic edge_seen;
	assign edge_seen = (lvl_q != lvl_last_q);

	// Width of the current level, saturating
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wid_q <= '0;
		end else if (edge_seen) begin
			wid_q <= sptp_pkg::sptp_wid_t'(1);
		end else if (wid_q != '1) begin
			wid_q <= wid_q + sptp_pkg::sptp_wid_t'(1);
		end
	end

	// ------------------------------------------------------------------------
	// Pulse events
	// ------------------------------------------------------------------------
	logic ctrl_en_q;
	logic cnt_pulse;
	logic str_end;
	logic str_short;
	logic lvl_zero;

	// Pulses shorter than the minimum width are treated as supply noise
	assign cnt_pulse = edge_seen && lvl_last_q == sptp_pkg::SPTP_LVL_COUNT && wid_q >= MIN_CYC;
	assign str_end   = edge_seen && lvl_last_q == sptp_pkg::SPTP_LVL_STROBE && wid_q >= MIN_CYC;
	assign str_short = (wid_q <= LONG_CYC);
	assign lvl_zero  = (lvl_q == sptp_pkg::SPTP_LVL_ZERO);

	// ------------------------------------------------------------------------
	// Sequence decoder
	// ------------------------------------------------------------------------
	sptp_pkg::sptp_state_t  state_q;
	sptp_pkg::sptp_addr_t   cnt_q;
	logic                   long_hit;

	// Strobe crosses the long threshold while an address is pending
	assign long_hit = state_q == sptp_pkg::SPTP_ST_ADDR && lvl_q == sptp_pkg::SPTP_LVL_STROBE
		&& !edge_seen && wid_q == LONG_CYC;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= sptp_pkg::SPTP_ST_IDLE;
		end else if (lvl_zero || !ctrl_en_q) begin
			state_q <= sptp_pkg::SPTP_ST_IDLE;
		end else begin
			case (state_q)
				sptp_pkg::SPTP_ST_IDLE: begin
					if (str_end && str_short) begin
						state_q <= sptp_pkg::SPTP_ST_KEY;
					end
				end
				sptp_pkg::SPTP_ST_KEY: begin
					if (str_end && !str_short) begin
						state_q <= sptp_pkg::SPTP_ST_IDLE;
					end else if (str_end && cnt_q >= KEY_MIN) begin
						state_q <= sptp_pkg::SPTP_ST_ADDR;
					end
				end
				sptp_pkg::SPTP_ST_ADDR: begin
					if (str_end) begin
						state_q <= sptp_pkg::SPTP_ST_IDLE;
					end
				end
				default: begin
					state_q <= sptp_pkg::SPTP_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (lvl_zero || str_end || state_q == sptp_pkg::SPTP_ST_IDLE) begin
			cnt_q <= '0;
		end else if (cnt_pulse && cnt_q != '1) begin
			cnt_q <= cnt_q + sptp_pkg::sptp_addr_t'(1);
		end
	end

	// ------------------------------------------------------------------------
	// Bitfields and fuses
	// ------------------------------------------------------------------------
	sptp_pkg::sptp_bits_t   vol_q;
	sptp_pkg::sptp_bits_t   fuse_q;
	logic                   vol_lock_q;
	logic                   sw_clear;
	logic                   short_set;
	logic                   set_ok;

	// lock fuse refuses every further setting
	assign set_ok    = !lock_fuse;
	assign short_set = state_q == sptp_pkg::SPTP_ST_ADDR && str_end && str_short && set_ok;

	// volatile bits; a set wins over a clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vol_q      <= '0;
			vol_lock_q <= 1'h0;
		end else begin
			vol_q <= ((lvl_zero || sw_clear) ? '0 : vol_q)
				| (short_set ? sptp_trial(cnt_q) : '0)
				| ((long_hit && set_ok) ? sptp_weight(cnt_q) : '0);
			vol_lock_q <= ((lvl_zero || sw_clear) ? 1'h0 : vol_lock_q)
				| (set_ok && (short_set || long_hit) && cnt_q == LOCK_A);
		end
	end

	// fuses never clear except by rst
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fuse_q    <= '0;
			lock_fuse <= 1'h0;
		end else if (long_hit && set_ok) begin
			fuse_q <= fuse_q | sptp_weight(cnt_q);
			if (cnt_q == LOCK_A) begin
				lock_fuse <= 1'h1;
			end
		end
	end

	// Blow current stays on until the strobe ends
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fuse_blow <= 1'h0;
			fuse_addr <= '0;
		end else if (long_hit && set_ok) begin
			fuse_blow <= 1'h1;
			fuse_addr <= cnt_q;
		end else if (edge_seen) begin
			fuse_blow <= 1'h0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			operate_switchpoint <= '0;
		end else begin
			operate_switchpoint <= vol_q | fuse_q;
		end
	end

	// ------------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------------
	logic wb_req;
	logic wb_wr;
	assign wb_req   = wb_cyc && wb_stb && !wb_ack;
	assign wb_wr    = wb_req && wb_we && wb_adr == `SPTP_OFS_CTRL && wb_sel[0];
	assign sw_clear = wb_wr && wb_dat_w[`SPTP_CTRL_CLR];

	// One-cycle acknowledge for every address
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wb_ack <= 1'h0;
		end else begin
			wb_ack <= wb_req;
		end
	end

	// Control: decoder enable
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_en_q <= `SPTP_CTRL_RST;
		end else if (wb_wr) begin
			ctrl_en_q <= wb_dat_w[`SPTP_CTRL_EN];
		end
	end

	// Read data; unmapped offsets read zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wb_dat_r <= '0;
		end else if (wb_req && !wb_we) begin
			wb_dat_r <= '0;
			case (wb_adr)
				`SPTP_OFS_CTRL: begin
					wb_dat_r[`SPTP_CTRL_EN] <= ctrl_en_q;
				end
				`SPTP_OFS_STATUS: begin
					wb_dat_r[`SPTP_ST_ARMED] <= (state_q == sptp_pkg::SPTP_ST_ADDR);
					wb_dat_r[`SPTP_ST_LOCK]  <= lock_fuse;
					wb_dat_r[`SPTP_ST_BLOW]  <= fuse_blow;
					wb_dat_r[`SPTP_ST_VLOCK] <= vol_lock_q;
					wb_dat_r[`SPTP_ST_CNT_LSB +: 7] <= cnt_q;
				end
				`SPTP_OFS_CALIB: begin
					wb_dat_r[5:0] <= operate_switchpoint;
					wb_dat_r[`SPTP_CAL_FUSE_LSB +: 6] <= fuse_q;
					wb_dat_r[`SPTP_CAL_VOL_LSB +: 6]  <= vol_q;
				end
				default: begin
					wb_dat_r <= '0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_key_arms_addr: assert property (state_q == sptp_pkg::SPTP_ST_KEY && str_end && str_short
		&& cnt_q >= KEY_MIN && ctrl_en_q && !lvl_zero |=> state_q == sptp_pkg::SPTP_ST_ADDR && cnt_q == '0)
		else $error("enable key did not arm addressing");
	a_key_too_short: assert property (state_q == sptp_pkg::SPTP_ST_KEY && str_end
		&& cnt_q < KEY_MIN |=> state_q != sptp_pkg::SPTP_ST_ADDR)
		else $error("addressing armed with too few count pulses");
	a_count_step: assert property (state_q == sptp_pkg::SPTP_ST_ADDR && cnt_pulse && !lvl_zero
		&& cnt_q != '1 |=> cnt_q == $past(cnt_q) + 7'h01)
		else $error("address counter did not step");
	a_idle_ignore: assert property (state_q == sptp_pkg::SPTP_ST_IDLE |=> cnt_q == '0)
		else $error("count pulses counted while not addressing");
	a_short_sets: assert property (short_set && !lvl_zero && !sw_clear
		|=> vol_q == ($past(vol_q) | sptp_trial($past(cnt_q)))
		##1 operate_switchpoint == ($past(vol_q) | $past(fuse_q)))
		else $error("short strobe did not set the volatile value");
	a_long_blows: assert property (long_hit && set_ok && cnt_q != '0 && cnt_q <= NBITS_A
		|=> fuse_blow && fuse_addr == $past(cnt_q) && (fuse_q & sptp_weight(fuse_addr)) != '0)
		else $error("long strobe did not blow the addressed fuse");
	a_fuse_sticky: assert property (1'h1 |=> (fuse_q & $past(fuse_q)) == $past(fuse_q))
		else $error("a blown fuse bit fell");
	a_zero_clears: assert property (lvl_zero && lvl_last_q == sptp_pkg::SPTP_LVL_ZERO
		|=> vol_q == '0 && state_q == sptp_pkg::SPTP_ST_IDLE)
		else $error("supply collapse left volatile state");
	a_lock_refuse: assert property (lock_fuse |=> $stable(fuse_q) && (vol_q & ~$past(vol_q)) == '0)
		else $error("bitfield set after lock");
	a_wb_ack_once: assert property (wb_req |=> wb_ack ##1 !wb_ack)
		else $error("bus acknowledge not one cycle");

	c_armed:   cover property (state_q == sptp_pkg::SPTP_ST_KEY ##1 state_q == sptp_pkg::SPTP_ST_ADDR);
	c_trial:   cover property (short_set && cnt_q > 7'h01);
	c_blow:    cover property (long_hit && cnt_q == 7'h03);
	c_locked:  cover property ($rose(lock_fuse));

endmodule

// ===== verif/sptp_prog_model.sv
/*
 * Programming instrument model: drives classified supply pulses.
 * Assumes a 10 MHz clock and a decoder filtering pulses under 200 cycles.
 */
`timescale 1ns/10ps

module sptp_prog_model (
	// Clock
	input  wire logic       clock,
	// Classified supply level
	output logic      [1:0] supply_class
);
	// ------------------------------------------------------------------
	// Pulse timing, in clock cycles
	// ------------------------------------------------------------------
	localparam int PW   = 210;  // Short pulse, just above 20 us
	localparam int OFF  = 210;  // Off time at hold level
	localparam int LONG = 3000; // Fuse pulse, 300 us

	// Supply starts collapsed
	initial supply_class = sptp_pkg::SPTP_LVL_ZERO;

	// Hold one level for n cycles
	task automatic level(input sptp_pkg::sptp_lvl_t lv, input int n);
		supply_class <= lv;
		repeat (n) @(posedge clock);
	endtask

	task automatic pulse(input sptp_pkg::sptp_lvl_t lv, input int w);
		level(lv, w);
		level(sptp_pkg::SPTP_LVL_HOLD, OFF);
	endtask

	task automatic send(input int key, input int adr, input logic blow);
		pulse(sptp_pkg::SPTP_LVL_STROBE, PW);
		repeat (key) pulse(sptp_pkg::SPTP_LVL_COUNT, PW);
		pulse(sptp_pkg::SPTP_LVL_STROBE, PW);
		repeat (adr) pulse(sptp_pkg::SPTP_LVL_COUNT, PW);
		pulse(sptp_pkg::SPTP_LVL_STROBE, blow ? LONG : PW);
	endtask

	task automatic drop();
		level(sptp_pkg::SPTP_LVL_ZERO, OFF);
		level(sptp_pkg::SPTP_LVL_HOLD, OFF);
	endtask
endmodule

// ===== verif/tb.sv
/*
 * Self-checking bench of the supply pulse trim programmer.
 * Assumes the programmer model and a one-cycle Wishbone answer.
 */
`timescale 1ns/10ps
`include "sptp_params.svh"

module tb;
	logic        clock, rst, wb_cyc, wb_stb, wb_we, wb_ack;
	logic        lock_fuse, fuse_blow;
	logic [3:0]  wb_adr, wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, rd;
	logic [1:0]  supply_class;
	logic [5:0]  operate_switchpoint;
	logic [6:0]  fuse_addr;
	int          mismatches, cmp_count, blow_cycles;

	sptp_top sptp_top_inst (.clock(clock), .rst(rst), .supply_class(supply_class),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
		.operate_switchpoint(operate_switchpoint), .lock_fuse(lock_fuse),
		.fuse_blow(fuse_blow), .fuse_addr(fuse_addr));
	sptp_prog_model prog (.clock(clock), .supply_class(supply_class));

	// ------------------------------------------------------------------
	// Clock and fuse current monitor
	// ------------------------------------------------------------------
	initial clock = 1'h0;
	always #50 clock = ~clock;
	// Counts edges at which the blow current is seen on
	always @(posedge clock) begin
		if (fuse_blow === 1'h1) blow_cycles <= blow_cycles + 1;
	end

	// ------------------------------------------------------------------
	// Compare, bus and closing tasks
	// ------------------------------------------------------------------
	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic chk_trim(input string nm, input logic [5:0] e);
		chk_word(nm, {26'h0, e}, {26'h0, operate_switchpoint});
	endtask
	task automatic wrap_up();
		$display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Single classic cycle, held until ack is seen
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		q = 32'h0;
		@(posedge clock);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack !== 1'h1 && n < 20);
		// Read data is taken at the edge where ack is sampled high
		q = wb_dat_r;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
		if (wb_ack !== 1'h1) begin
			mismatches++;
			wrap_up();
		end
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Reset values and an unmapped place
	task automatic t_regs();
		wb(1'h0, 4'h0, 32'h0, rd);
		chk_word("ctrl", 32'h1, rd);
		wb(1'h1, 4'hC, 32'hFFFFFFFF, rd);
		wb(1'h0, 4'hC, 32'h0, rd);
		chk_word("unmapped", 32'h0, rd);
	endtask
	// Trial value, provisional add, supply drop
	task automatic t_trial();
		prog.send(7, 5, 1'h0);
		chk_trim("trial", 6'h05);
		prog.send(8, 2, 1'h0);
		chk_trim("added", 6'h07);
		prog.drop();
		chk_trim("dropped", 6'h00);
	endtask
	// Key with six counts only
	task automatic t_bad_key();
		prog.send(6, 3, 1'h0);
		chk_trim("short key", 6'h00);
		wb(1'h1, 4'h0, 32'h0, rd);
		wb(1'h0, 4'h0, 32'h0, rd);
		chk_word("ctrl off", 32'h0, rd);
		prog.send(7, 1, 1'h0);
		chk_trim("disabled", 6'h00);
		wb(1'h1, 4'h0, 32'h1, rd);
	endtask
	// Permanent value 5 as addresses 3 and 1; zero bits never blown
	task automatic t_fuse();
		int b0;
		b0 = blow_cycles;
		prog.send(7, 3, 1'h1);
		chk_word("blow cycles", 32'(prog.LONG - `SPTP_LONG_CYC), 32'(blow_cycles - b0));
		chk_word("fuse addr", 32'h3, {25'h0, fuse_addr});
		prog.drop();
		chk_trim("fuse 3", 6'h04);
		prog.send(7, 1, 1'h1);
		prog.drop();
		chk_trim("fuse 1", 6'h05);
		wb(1'h0, 4'h8, 32'h0, rd);
		chk_word("calib", 32'h505, rd);
	endtask
	// Clear keeps fuses, lock refuses sets
	task automatic t_lock();
		prog.send(7, 2, 1'h0);
		chk_trim("trial over fuse", 6'h07);
		wb(1'h1, 4'h0, 32'h3, rd);
		repeat (4) @(posedge clock);
		chk_trim("cleared", 6'h05);
		chk_word("unlocked", 32'h0, {31'h0, lock_fuse});
		prog.send(7, 65, 1'h1);
		chk_word("locked", 32'h1, {31'h0, lock_fuse});
		wb(1'h0, 4'h4, 32'h0, rd);
		chk_word("status", 32'hA, rd);
		prog.send(7, 2, 1'h0);
		chk_trim("after lock", 6'h05);
	endtask

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		rst = 1'h1;
		wb_cyc = 1'h0;
		wb_stb = 1'h0;
		wb_we = 1'h0;
		wb_adr = 4'h0;
		wb_sel = 4'hF;
		wb_dat_w = 32'h0;
		mismatches = 0;
		cmp_count = 0;
		repeat (10) @(posedge clock);
		rst <= 1'h0;
		prog.drop();
		t_regs();
		t_trial();
		t_bad_key();
		t_fuse();
		t_lock();
		wrap_up();
	end
	initial begin
		#9500000;
		mismatches++;
		wrap_up();
	end
endmodule
